// File: shared/irq_seq_params.svh
// offsets, field positions, reset values and counts of the sequencer
`ifndef IRQ_SEQ_PARAMS_SVH
`define IRQ_SEQ_PARAMS_SVH

// bytes of machine state saved per serviced interrupt
`define STACK_BYTES 3'h5
`define STACK_LAST 3'h4
// timer counter values that mark the decrement onto zero
`define TIMER_ONE 8'h01
`define TIMER_ZERO 8'h00
// miscellaneous register bit that disables the second request
`define MISC_SECOND_DIS_BIT 6
// reset values: flags clear, masks set
`define RST_FLAG 1'b0
`define RST_MASK 1'b1
// default vector addresses, overridable per instance
`define VEC_EXT_DEFAULT 16'hfffa
`define VEC_TIMER_DEFAULT 16'hfff8
`define VEC_TWAIT_DEFAULT 16'hfff6
`define VEC_SWT_DEFAULT 16'hfffc

`endif

// File: shared/irq_seq_pkg.sv
// types shared by the interrupt sequencer and its request latch
package irq_seq_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_STACK = 3'b001,
        ST_VECTOR = 3'b010,
        ST_UNSTACK = 3'b011,
        ST_WAIT = 3'b100
    } seq_state_t;

    typedef enum logic [1:0] {
        SRC_EXT = 2'b00,
        SRC_SECOND = 2'b01,
        SRC_TIMER = 2'b10,
        SRC_SOFT = 2'b11
    } irq_src_t;

    // request latch state
    typedef struct packed {
        logic line_prev;
        logic held;
    } req_latch_t;

    // whole sequencer state
    typedef struct packed {
        seq_state_t state;
        irq_src_t src;
        logic [2:0] count;
        logic i_bit;
        logic timer_request_flag;
        logic timer_request_mask_bit;
        logic [7:0] timer_prev;
        logic woke_by_timer;
        logic line_level;
        logic [15:0] vector_addr;
        logic vector_load;
        logic stack_push;
        logic stack_pop;
        logic wake;
    } seq_regs_t;

endpackage

// File: hw/request_latch.sv
// holds one external request line as a pending request
`timescale 1ns/1ns
`include "irq_seq_params.svh"

module request_latch #(
    parameter bit LEVEL_SENSE = 1'b0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic request_n,
    input wire logic ack,
    output logic pending
);

    irq_seq_pkg::req_latch_t r;
    irq_seq_pkg::req_latch_t next_r;
    logic fall;

    // falling edge only: line must return high to re-arm the latch
    assign fall = r.line_prev & ~request_n;

    always_comb begin
        next_r = r;
        next_r.line_prev = request_n;
        if (ack) begin
            next_r.held = `RST_FLAG;
        end
        // a new edge in the ack cycle is kept, set beats clear
        if (fall) begin
            next_r.held = 1'b1; // [R14]
        end
    end

    // level mode follows the wire-ored line directly
    assign pending = LEVEL_SENSE ? ~request_n : r.held; // [R13]

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            r.line_prev <= 1'b1;
            r.held <= `RST_FLAG; // [R21]
        end else begin
            r <= next_r;
        end
    end

endmodule

// File: hw/cpu_interrupt_sequencer.sv
// interrupt recognition, priority, stacking and vectoring of the core
// How it works
// [R1] requests wait for instruction completion
// [R2] external beats timer; timer stays pending
// [R3] branch sees primary line despite mask
// [R4] timer flag sets on count 01 to 00
// [R5] timer interrupt needs global mask clear
// [R6] set mask, stack, load vector, run
// [R7] timer wake from wait uses wait vector
// [R8] external wake leaves normal timer vector
// [R9] servicing never clears the timer flag
// [R10] return instruction unstacks and resumes program
// [R11] global mask set blocks all hardware
// [R12] second request needs misc bit 6 clear
// [R13] level option only on static variant
// [R14] edge requests latched internally
// [R15] source holds line low one cycle; the bench source model holds it low for len cycles, 1 to 3
// [R16] source releases line high to re-arm
// [R17] second request shares the timer vector
// [R18] software trap ignores the global mask
// [R19] pending hardware holds off instruction fetch
// [R20] software trap has its own vector
// [R21] reset clears flags, sets masks
// [R22] five stack bytes per interrupt
// [R23] flag cleared before service drops interrupt
// [R24] vector addresses are block parameters
`timescale 1ns/1ns
`include "irq_seq_params.svh"

module cpu_interrupt_sequencer #(
    parameter bit STATIC_LOGIC = 1'b1,
    parameter bit LEVEL_SENSE = 1'b0,
    parameter logic [15:0] VEC_EXT = `VEC_EXT_DEFAULT, // [R24]
    parameter logic [15:0] VEC_TIMER = `VEC_TIMER_DEFAULT,
    parameter logic [15:0] VEC_TIMER_WAIT = `VEC_TWAIT_DEFAULT,
    parameter logic [15:0] VEC_SOFT = `VEC_SWT_DEFAULT
) (
    input wire logic core_clk,
    input wire logic rst_n,
    // external request pins, active low, and the miscellaneous register
    input wire logic ext_request_n,
    input wire logic second_external_request_pin_n,
    input wire logic [7:0] misc_reg,
    // timer counter and its control bits
    input wire logic [7:0] timer_count,
    input wire logic timer_ctrl_write,
    input wire logic timer_flag_wdata,
    input wire logic timer_mask_wdata,
    // core sequencer events, one-cycle pulses, and the restored mask bit level
    input wire logic instr_done,
    input wire logic mask_set,
    input wire logic mask_clear,
    input wire logic software_trap_instruction,
    input wire logic return_from_trap_instruction,
    input wire logic wait_enter,
    input wire logic restored_i_bit,
    // status and sequencing outputs
    output logic i_bit,
    output logic timer_request_flag,
    output logic timer_request_mask_bit,
    output logic request_line_level,
    output logic fetch_hold,
    output logic in_wait,
    output logic wake,
    output logic stack_push,
    output logic stack_pop,
    output logic [2:0] stack_index,
    output logic vector_load,
    output logic [15:0] vector_addr,
    output logic [1:0] service_source
);

    irq_seq_pkg::seq_regs_t r;
    irq_seq_pkg::seq_regs_t next_r;
    logic ext_pending;
    logic second_pending;
    logic ext_ack;
    logic second_ack;
    logic timer_event;
    logic timer_live;
    logic ext_live;
    logic second_live;
    logic hw_live;
    irq_seq_pkg::irq_src_t hw_src;

    // dynamic variant cannot hold a level request
    localparam bit LEVEL_OK = STATIC_LOGIC & LEVEL_SENSE; // [R13]

    request_latch #(
        .LEVEL_SENSE(LEVEL_OK)
    ) u_ext_latch (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .request_n(ext_request_n),
        .ack(ext_ack),
        .pending(ext_pending)
    );

    request_latch #(
        .LEVEL_SENSE(LEVEL_OK)
    ) u_second_latch (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .request_n(second_external_request_pin_n),
        .ack(second_ack),
        .pending(second_pending)
    );

    // vector for a source; wait flag picks the timer wait vector
    function automatic logic [15:0] pick_vector(
        input irq_seq_pkg::irq_src_t src,
        input logic from_wait
    );
        logic [15:0] v;
        v = VEC_EXT;
        case (src)
            irq_seq_pkg::SRC_EXT: v = VEC_EXT;
            irq_seq_pkg::SRC_SECOND: v = VEC_TIMER; // [R17]
            irq_seq_pkg::SRC_TIMER: begin
                v = from_wait ? VEC_TIMER_WAIT : VEC_TIMER; // [R7] [R8]
            end
            irq_seq_pkg::SRC_SOFT: v = VEC_SOFT; // [R20]
            default: v = VEC_EXT;
        endcase
        return v;
    endfunction

    // byte counter shared by the push and pop runs
    function automatic logic [2:0] step_count(input logic [2:0] c);
        return c + 3'h1;
    endfunction

    // last byte of a five-byte run, for entry and return alike
    function automatic logic run_end(input logic [2:0] c);
        return c == `STACK_LAST;
    endfunction

    // decrement onto zero, seen as a change of the counter value
    // the counter lives outside; only its value is watched here
    assign timer_event = (r.timer_prev == `TIMER_ONE) &&
                         (timer_count == `TIMER_ZERO); // [R4]

    // qualify each source; the global mask gates all of them
    assign ext_live = ext_pending & ~r.i_bit; // [R11]
    assign second_live = second_pending & ~r.i_bit &
                         ~misc_reg[`MISC_SECOND_DIS_BIT]; // [R12]
    assign timer_live = r.timer_request_flag &
                        ~r.timer_request_mask_bit & ~r.i_bit; // [R5]
    assign hw_live = ext_live | second_live | timer_live;

    // external sources first, timer last
    always_comb begin
        if (ext_live) begin
            hw_src = irq_seq_pkg::SRC_EXT; // [R2]
        end else if (second_live) begin
            hw_src = irq_seq_pkg::SRC_SECOND;
        end else begin
            hw_src = irq_seq_pkg::SRC_TIMER;
        end
    end

    // next-state logic for the whole sequencer
    always_comb begin
        next_r = r;
        next_r.timer_prev = timer_count;
        next_r.line_level = ext_request_n; // [R3]
        next_r.vector_load = 1'b0;
        next_r.stack_push = 1'b0;
        next_r.stack_pop = 1'b0;
        next_r.wake = 1'b0;
        ext_ack = 1'b0;
        second_ack = 1'b0;

        // software mask control from the core
        if (mask_set) begin
            next_r.i_bit = 1'b1;
        end else if (mask_clear) begin
            next_r.i_bit = 1'b0;
        end

        // software write first, so a same-cycle count event wins
        if (timer_ctrl_write) begin
            next_r.timer_request_flag = timer_flag_wdata; // [R23]
            next_r.timer_request_mask_bit = timer_mask_wdata;
        end
        if (timer_event) begin
            next_r.timer_request_flag = 1'b1; // [R4]
        end

        case (r.state)
            irq_seq_pkg::ST_IDLE: begin
                if (instr_done && hw_live) begin
                    // taken only at an instruction boundary
                    next_r.state = irq_seq_pkg::ST_STACK; // [R1]
                    next_r.src = hw_src;
                    next_r.i_bit = 1'b1; // [R6]
                    next_r.count = 3'h0;
                    next_r.woke_by_timer = 1'b0;
                    ext_ack = (hw_src == irq_seq_pkg::SRC_EXT);
                    second_ack = (hw_src == irq_seq_pkg::SRC_SECOND);
                end else if (software_trap_instruction) begin
                    // non-maskable: taken whatever the mask holds
                    next_r.state = irq_seq_pkg::ST_STACK; // [R18]
                    next_r.src = irq_seq_pkg::SRC_SOFT;
                    next_r.i_bit = 1'b1; // [R18]
                    next_r.count = 3'h0;
                    next_r.woke_by_timer = 1'b0;
                end else if (return_from_trap_instruction) begin
                    next_r.state = irq_seq_pkg::ST_UNSTACK; // [R10]
                    next_r.count = 3'h0;
                end else if (wait_enter) begin
                    next_r.state = irq_seq_pkg::ST_WAIT;
                end
            end
            irq_seq_pkg::ST_WAIT: begin
                // no instruction runs, so any live request wakes
                if (hw_live) begin
                    next_r.state = irq_seq_pkg::ST_STACK;
                    next_r.src = hw_src;
                    next_r.i_bit = 1'b1; // [R6]
                    next_r.count = 3'h0;
                    next_r.wake = 1'b1;
                    // only a timer wake earns the wait vector
                    next_r.woke_by_timer =
                        (hw_src == irq_seq_pkg::SRC_TIMER); // [R7] [R8]
                    ext_ack = (hw_src == irq_seq_pkg::SRC_EXT);
                    second_ack = (hw_src == irq_seq_pkg::SRC_SECOND);
                end
            end
            irq_seq_pkg::ST_STACK: begin
                // mask already set, now save the machine state
                next_r.stack_push = 1'b1; // [R6]
                next_r.count = step_count(r.count);
                if (run_end(r.count)) begin
                    next_r.state = irq_seq_pkg::ST_VECTOR; // [R22]
                end
            end
            irq_seq_pkg::ST_VECTOR: begin
                // count keeps five here so stack_index shows the run
                // flag is left alone; software must clear it
                next_r.vector_addr = pick_vector(r.src,
                                                 r.woke_by_timer); // [R9]
                next_r.vector_load = 1'b1; // [R6]
                next_r.woke_by_timer = 1'b0;
                next_r.state = irq_seq_pkg::ST_IDLE;
            end
            irq_seq_pkg::ST_UNSTACK: begin
                next_r.stack_pop = 1'b1; // [R10]
                next_r.count = step_count(r.count);
                if (run_end(r.count)) begin
                    // mask comes back from the saved condition codes
                    next_r.i_bit = restored_i_bit; // [R10]
                    next_r.state = irq_seq_pkg::ST_IDLE;
                end
            end
            default: begin
                next_r.state = irq_seq_pkg::ST_IDLE;
            end
        endcase
    end

    // sequencer registers; masks come up set, flags clear
    // vector_addr reads zero until the first service is taken
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            r.state <= irq_seq_pkg::ST_IDLE;
            r.src <= irq_seq_pkg::SRC_EXT;
            r.count <= 3'h0;
            r.i_bit <= `RST_MASK; // [R21]
            r.timer_request_flag <= `RST_FLAG; // [R21]
            r.timer_request_mask_bit <= `RST_MASK; // [R21]
            r.timer_prev <= `TIMER_ZERO;
            r.woke_by_timer <= 1'b0;
            r.line_level <= 1'b1;
            r.vector_addr <= 16'h0000;
            r.vector_load <= 1'b0;
            r.stack_push <= 1'b0;
            r.stack_pop <= 1'b0;
            r.wake <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // hold the fetch while hardware is owed service or in sequence
    // combinational so the core stalls in the cycle a request goes
    // live; a registered hold would let one more fetch slip through
    assign fetch_hold = hw_live ||
                        (r.state != irq_seq_pkg::ST_IDLE); // [R19]

    // registered status and sequencing outputs
    assign i_bit = r.i_bit;
    assign timer_request_flag = r.timer_request_flag;
    assign timer_request_mask_bit = r.timer_request_mask_bit;
    assign request_line_level = r.line_level; // [R3]
    assign in_wait = (r.state == irq_seq_pkg::ST_WAIT);
    assign wake = r.wake;
    assign stack_push = r.stack_push;
    assign stack_pop = r.stack_pop;
    assign stack_index = r.count;
    assign vector_load = r.vector_load;
    assign vector_addr = r.vector_addr;
    assign service_source = r.src;

endmodule

// File: tb/ext_source_model.sv
// external request source driving the primary request pin
`timescale 1ns/1ns

module ext_source_model (
    input wire logic core_clk,
    input wire logic fire,
    input wire logic [1:0] len,
    output logic req_n
);
    logic [1:0] left = 2'h0;

    // low for len cycles, at least one, then released high to re-arm
    always @(posedge core_clk) begin
        if (fire) begin
            left <= (len == 2'h0) ? 2'h1 : len;
        end else if (left != 2'h0) begin
            left <= left - 2'h1;
        end
    end
    assign req_n = (left == 2'h0);
endmodule

// File: tb/cpu_interrupt_sequencer_props.sv
// port assertions for the interrupt sequencer
`timescale 1ns/1ns

module irq_seq_props #(
    parameter logic [15:0] VEC_EXT = 16'h0000,
    parameter logic [15:0] VEC_TIMER = 16'h0000,
    parameter logic [15:0] VEC_SOFT = 16'h0000
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ext_request_n,
    input wire logic [7:0] timer_count,
    input wire logic timer_ctrl_write,
    input wire logic i_bit,
    input wire logic timer_request_flag,
    input wire logic request_line_level,
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic [2:0] stack_index,
    input wire logic wake,
    input wire logic vector_load,
    input wire logic [15:0] vector_addr,
    input wire logic [1:0] service_source
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // stacking runs and their order against mask and vector
    a_push_five: assert property (
        $rose(stack_push) |-> stack_push[*5] ##1 !stack_push)
        else $error("stack push run is not five cycles");
    a_pop_five: assert property (
        $rose(stack_pop) |-> stack_pop[*5] ##1 !stack_pop)
        else $error("stack pop run is not five cycles");
    a_index_bytes: assert property (
        $fell(stack_push) |-> stack_index == 3'h5)
        else $error("stack run did not count five bytes");
    a_wake_stacks: assert property (
        wake |=> $rose(stack_push))
        else $error("wake from wait did not start stacking");
    a_mask_first: assert property (
        $rose(stack_push) |-> $past(i_bit))
        else $error("stacking began before the mask was set");
    a_vector_next: assert property (
        $past(rst_n) && $fell(stack_push) |-> vector_load)
        else $error("vector not loaded right after stacking");
    a_no_hw_masked: assert property (
        $rose(stack_push) && service_source != irq_seq_pkg::SRC_SOFT
        |-> !$past(i_bit, 2))
        else $error("hardware entry taken while masked");
    // vector per source
    a_soft_vec: assert property (
        vector_load && service_source == irq_seq_pkg::SRC_SOFT
        |-> vector_addr == VEC_SOFT)
        else $error("software trap vector wrong");
    a_ext_vec: assert property (
        vector_load && service_source == irq_seq_pkg::SRC_EXT
        |-> vector_addr == VEC_EXT)
        else $error("external vector wrong");
    a_second_vec: assert property (
        vector_load && service_source == irq_seq_pkg::SRC_SECOND
        |-> vector_addr == VEC_TIMER)
        else $error("second request vector wrong");
    // timer flag and branch line
    a_timer_event: assert property (
        $past(rst_n) && $past(timer_count) == 8'h01 && timer_count == 8'h00
        |-> ##[1:2] timer_request_flag)
        else $error("timer flag missed the count onto zero");
    a_flag_held: assert property (
        timer_request_flag && !timer_ctrl_write |=> timer_request_flag)
        else $error("timer flag cleared without a write");
    a_line_level: assert property (
        $past(rst_n) |-> request_line_level == $past(ext_request_n))
        else $error("branch line level does not follow the pin");

    c_soft: cover property (vector_load
        && service_source == irq_seq_pkg::SRC_SOFT);
    c_timer: cover property (vector_load
        && service_source == irq_seq_pkg::SRC_TIMER);
    c_return: cover property ($rose(stack_pop));
endmodule

bind cpu_interrupt_sequencer irq_seq_props #(.VEC_EXT(VEC_EXT),
    .VEC_TIMER(VEC_TIMER), .VEC_SOFT(VEC_SOFT)) props_u (
    .core_clk(core_clk), .rst_n(rst_n), .ext_request_n(ext_request_n),
    .timer_count(timer_count), .timer_ctrl_write(timer_ctrl_write),
    .i_bit(i_bit), .timer_request_flag(timer_request_flag),
    .request_line_level(request_line_level), .stack_push(stack_push),
    .stack_pop(stack_pop), .stack_index(stack_index), .wake(wake),
    .vector_load(vector_load),
    .vector_addr(vector_addr), .service_source(service_source));

// File: tb/cpu_interrupt_sequencer_bench.sv
// self-checking bench for the interrupt sequencer
`timescale 1ns/1ns
`include "irq_seq_params.svh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
    mismatches++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
    $time, got, exp); end end

module cpu_interrupt_sequencer_bench;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic fire = 1'b0;
    logic [1:0] fire_len = 2'h1;
    logic ext_n, second_n = 1'b1, twr = 1'b0, tflag = 1'b0, tmask = 1'b1;
    logic restored = 1'b1;
    logic [7:0] misc_reg = 8'h00, timer_count = 8'h80;
    logic [5:0] ev = 6'h00;
    logic i_bit, tr_flag, tr_mask, fetch_hold, vector_load, in_wait, wake;
    logic [15:0] vector_addr;
    logic [1:0] service_source;
    logic [17:0] expq[$];
    int mismatches = 0, num_checks = 0, cycles = 0, wakes = 0;

    ext_source_model src_u (.core_clk(core_clk), .fire(fire),
        .len(fire_len), .req_n(ext_n));
    cpu_interrupt_sequencer dut_u (.core_clk(core_clk), .rst_n(rst_n),
        .ext_request_n(ext_n), .second_external_request_pin_n(second_n),
        .misc_reg(misc_reg), .timer_count(timer_count),
        .timer_ctrl_write(twr), .timer_flag_wdata(tflag),
        .timer_mask_wdata(tmask), .instr_done(ev[0]), .mask_set(ev[1]),
        .mask_clear(ev[2]), .software_trap_instruction(ev[3]),
        .return_from_trap_instruction(ev[4]), .wait_enter(ev[5]),
        .restored_i_bit(restored), .i_bit(i_bit),
        .timer_request_flag(tr_flag), .timer_request_mask_bit(tr_mask),
        .request_line_level(), .fetch_hold(fetch_hold),
        .in_wait(in_wait),
        .wake(wake), .stack_push(), .stack_pop(), .stack_index(),
        .vector_load(vector_load), .vector_addr(vector_addr),
        .service_source(service_source));

    initial forever #50 core_clk = ~core_clk;

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // hang guard, run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            wrap_up();
        end
    end

    // every vector load must match the oldest note
    always @(negedge core_clk) begin
        if (rst_n && vector_load) begin
            if (expq.size() == 0) begin
                `CHK(vector_load, 1'b0)
            end else begin
                `CHK({service_source, vector_addr}, expq.pop_front())
            end
        end
    end

    // wake pulses stand one cycle; count them mid-cycle
    always @(negedge core_clk) begin
        if (rst_n && wake) begin
            wakes++;
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic pulse(input logic [5:0] m);
        @(posedge core_clk);
        ev <= m;
        @(posedge core_clk);
        ev <= 6'h00;
    endtask
    task automatic ext_fire;
        @(posedge core_clk);
        fire <= 1'b1;
        fire_len <= 2'($urandom_range(1, 3));
        @(posedge core_clk);
        fire <= 1'b0;
        cyc(4);
    endtask
    task automatic tick;
        @(posedge core_clk);
        timer_count <= 8'h01;
        @(posedge core_clk);
        timer_count <= 8'h00;
        cyc(3);
    endtask
    task automatic twrite(input logic f, input logic m);
        @(posedge core_clk);
        twr <= 1'b1;
        tflag <= f;
        tmask <= m;
        @(posedge core_clk);
        twr <= 1'b0;
    endtask
    task automatic ret;
        restored <= 1'b0;
        pulse(6'h10);
        cyc(8);
    endtask
    task automatic boundary;
        pulse(6'h01);
        cyc(10);
    endtask

    // main sequence, expected vectors noted before each trigger
    initial begin
        void'($urandom(32'he533));
        misc_reg <= 8'($urandom()) | 8'h40;
        cyc(3);
        rst_n <= 1'b1;
        cyc(2);
        `CHK(i_bit, 1'b1)
        `CHK(tr_flag, 1'b0)
        `CHK(tr_mask, 1'b1)
        ext_fire();
        boundary();
        expq.push_back({irq_seq_pkg::SRC_SOFT, `VEC_SWT_DEFAULT});
        pulse(6'h08);
        cyc(10);
        `CHK(i_bit, 1'b1)
        ret();
        `CHK(i_bit, 1'b0)
        `CHK(fetch_hold, 1'b1)
        expq.push_back({irq_seq_pkg::SRC_EXT, `VEC_EXT_DEFAULT});
        boundary();
        ret();
        $display("test masked_and_trap done");
        twrite(1'b0, 1'b0);
        tick();
        `CHK(tr_flag, 1'b1)
        ext_fire();
        `CHK(fetch_hold, 1'b1)
        expq.push_back({irq_seq_pkg::SRC_EXT, `VEC_EXT_DEFAULT});
        boundary();
        `CHK(tr_flag, 1'b1)
        ret();
        expq.push_back({irq_seq_pkg::SRC_TIMER, `VEC_TIMER_DEFAULT});
        boundary();
        ret();
        twrite(1'b0, 1'b0);
        $display("test priority done");
        @(posedge core_clk);
        second_n <= 1'b0;
        @(posedge core_clk);
        second_n <= 1'b1;
        boundary();
        misc_reg <= misc_reg & 8'hbf;
        expq.push_back({irq_seq_pkg::SRC_SECOND, `VEC_TIMER_DEFAULT});
        boundary();
        ret();
        $display("test second_request done");
        pulse(6'h20);
        cyc(1);
        `CHK(in_wait, 1'b1)
        expq.push_back({irq_seq_pkg::SRC_TIMER, `VEC_TWAIT_DEFAULT});
        tick();
        cyc(10);
        `CHK(in_wait, 1'b0)
        twrite(1'b0, 1'b0);
        ret();
        $display("test timer_wake done");
        pulse(6'h20);
        expq.push_back({irq_seq_pkg::SRC_EXT, `VEC_EXT_DEFAULT});
        ext_fire();
        cyc(10);
        ret();
        expq.push_back({irq_seq_pkg::SRC_TIMER, `VEC_TIMER_DEFAULT});
        tick();
        boundary();
        twrite(1'b0, 1'b0);
        ret();
        `CHK(wakes, 2)
        $display("test ext_wake done");
        pulse(6'h02);
        tick();
        boundary();
        twrite(1'b0, 1'b0);
        pulse(6'h04);
        boundary();
        `CHK(32'(expq.size()), 32'h0)
        $display("test dropped_timer done");
        wrap_up();
    end
endmodule
